// file: verilog/csb_consts.vh
// shared constants for the chip-select page bus sequencer
// assumes one 10 MHz bus clock; all counts are in bus clock cycles
`ifndef CSB_CONSTS_VH
`define CSB_CONSTS_VH

// external address and data widths
`define CSB_ADDR_W 26
`define CSB_DATA_W 32
`define CSB_LINE_W 128

// access size encodings on the request port (log2 of bytes)
`define CSB_SIZE_BYTE 2'h0
`define CSB_SIZE_WORD 2'h1
`define CSB_SIZE_LONG 2'h2

// log2 of the bytes in one cache line replacement
`define CSB_LINE_LOG 3'h4

// external channel width encodings (log2 of lane count)
`define CSB_BUS_8 2'h0
`define CSB_BUS_16 2'h1
`define CSB_BUS_32 2'h2

// strobe mode select values
`define CSB_STROBE_BYTE 1'b0
`define CSB_STROBE_ONE 1'b1

// cycle wait counters saturate at the largest programmable count
`define CSB_WAIT_MAX 5'h1F

// reset values of the pin outputs
`define CSB_STROBES_IDLE 4'hF
`define CSB_ADDR_RESET 26'h0000000
`define CSB_DATA_RESET 32'h00000000

`endif

// file: verilog/csb_sync.v
// two-stage synchroniser for signals arriving from the external pins
// assumes the pins are asynchronous to clk; output lags the pin by two edges
`timescale 1ns/1ps

module csb_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire rstn,
    input wire [WIDTH-1:0] pinIn,
    output reg [WIDTH-1:0] syncOut
);

// first stage, read only by the second stage
reg [WIDTH-1:0] stage1_reg;

// both stages reset to the idle level of the pin
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        stage1_reg <= INIT;
        syncOut <= INIT;
    end
    else
    begin
        stage1_reg <= pinIn;
        syncOut <= stage1_reg;
    end
end

endmodule

// file: verilog/csb_page_sequencer.v
// chip-select space bus sequencer: normal and page read/write beats
// assumes an internal master holding request fields while reqValid is high,
// and asynchronous memory outside; all pin outputs come from flip-flops
`timescale 1ns/1ps
`include "csb_consts.vh"

module csb_page_sequencer (
    input wire clk,
    input wire rstn,
    input wire reqValid,
    input wire reqWrite,
    input wire reqBurst,
    input wire [1:0] reqSize,
    input wire [`CSB_ADDR_W-1:0] reqAddr,
    input wire [`CSB_LINE_W-1:0] reqData,
    output reg reqReady,
    output reg rdValid,
    output reg [`CSB_DATA_W-1:0] rdData,
    input wire [1:0] busWidth,
    input wire strobe_mode_sel,
    input wire page_read_mode_sel,
    input wire page_read_enable,
    input wire page_write_enable,
    input wire [1:0] page_boundary_sel,
    input wire ext_wait_enable,
    input wire [4:0] read_cycle_wait_cnt,
    input wire [4:0] write_cycle_wait_cnt,
    input wire [4:0] page_read_wait_cnt,
    input wire [4:0] page_write_wait_cnt,
    input wire [2:0] csAssertWait,
    input wire [2:0] rdAssertWait,
    input wire [2:0] wrAssertWait,
    input wire [2:0] write_data_delay_cycles,
    input wire [2:0] cs_delay_cycles,
    input wire extWaitN,
    input wire [`CSB_DATA_W-1:0] dataIn,
    output reg chip_select_n,
    output reg readStrobeN,
    output reg [3:0] writeStrobeN,
    output reg commonWriteN,
    output reg [3:0] byte_control_n,
    output reg rdWrDir,
    output reg [`CSB_ADDR_W-1:0] addrOut,
    output reg [`CSB_DATA_W-1:0] dataOut,
    output reg dataOe
);

// sequencer states: start cycle, waits, write delay, cs delay, sample
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_START = 3'h1;
localparam [2:0] S_WAIT = 3'h2;
localparam [2:0] S_WDLY = 3'h3;
localparam [2:0] S_CSDLY = 3'h4;
localparam [2:0] S_RSAMP = 3'h5;

// lanes touched by one beat, one bit per byte lane
function [3:0] laneMask;
    input [1:0] a;
    input [1:0] beatLog;
    input [1:0] busLog;
    begin
        laneMask = 4'h1;
        if (busLog == `CSB_BUS_16)
            laneMask = (beatLog == `CSB_SIZE_BYTE) ? (a[0] ? 4'h2 : 4'h1) : 4'h3;
        else if (busLog == `CSB_BUS_32)
        begin
            if (beatLog == `CSB_SIZE_BYTE)
                laneMask = 4'h1 << a;
            else if (beatLog == `CSB_SIZE_WORD)
                laneMask = a[1] ? 4'hC : 4'h3;
            else
                laneMask = 4'hF;
        end
    end
endfunction

// address as presented on the pins for the channel width
function [`CSB_ADDR_W-1:0] alignAddr;
    input [`CSB_ADDR_W-1:0] a;
    input [1:0] busLog;
    begin
        alignAddr = a;
        if (busLog == `CSB_BUS_32)
            alignAddr = {a[`CSB_ADDR_W-1:2], 2'b00};
        else if (busLog == `CSB_BUS_16)
            alignAddr = {a[`CSB_ADDR_W-1:1], 1'b0};
        // 8-bit bus keeps every address bit
    end
endfunction

// on 8 and 16-bit buses move the addressed part of a longword onto the low lanes; 32-bit keeps all lanes
function [`CSB_DATA_W-1:0] laneData;
    input [`CSB_DATA_W-1:0] w;
    input [1:0] a;
    input [1:0] busLog;
    begin
        laneData = w;
        if (busLog == `CSB_BUS_16)
            laneData = {16'h0000, a[1] ? w[31:16] : w[15:0]};
        else if (busLog == `CSB_BUS_8)
            laneData = {24'h000000, w[8*a +: 8]};
    end
endfunction

// true when an address sits on the start of a new page
function crossBound;
    input [`CSB_ADDR_W-1:0] a;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: crossBound = (a[3:0] == 4'h0);
            2'h1: crossBound = (a[4:0] == 5'h00);
            2'h2: crossBound = (a[5:0] == 6'h00);
            default: crossBound = (a[6:0] == 7'h00);
        endcase
    end
endfunction

// sequencer state and per-access context
reg [2:0] st_reg, st_next;
reg [4:0] k_reg, k_next;         // wait cycles elapsed in this beat
reg [2:0] dly_reg, dly_next;     // write or cs delay cycles left
reg first_reg, first_next;       // beat uses normal, not page, waits
reg wr_reg, wr_next;
reg burst_reg, burst_next;
reg page_reg, page_next;
reg [1:0] beatLog_reg, beatLog_next;
reg [1:0] busLog_reg, busLog_next;
reg [3:0] left_reg, left_next;   // beats remaining after this one
reg [`CSB_ADDR_W-1:0] addr_reg, addr_next;
reg [`CSB_LINE_W-1:0] line_reg, line_next;
reg sampleP1_reg, sampleP2_reg;  // read sample pipeline
reg adv;                         // step to the following beat

// synchronised pins
wire waitSync;
wire [`CSB_DATA_W-1:0] dataSync;

csb_sync #(
    .WIDTH(1),
    .INIT(1'b1)
) uWaitSync (
    .clk(clk),
    .rstn(rstn),
    .pinIn(extWaitN),
    .syncOut(waitSync)
);

// read data take the same two-edge path as the wait pin
csb_sync #(
    .WIDTH(`CSB_DATA_W),
    .INIT(`CSB_DATA_RESET)
) uDataSync (
    .clk(clk),
    .rstn(rstn),
    .pinIn(dataIn),
    .syncOut(dataSync)
);

// wait pin honoured only when enabled
// sync output reflects the pin two cycles back
// synchroniser runs even between bus cycles
wire extHold = ext_wait_enable & ~waitSync;

// beat after each start cycle uses cycle waits, page continuation beats page waits
// counts of 0 to 31 cycles after the start cycle
wire [4:0] target = first_reg ?
    (wr_reg ? write_cycle_wait_cnt : read_cycle_wait_cnt) :
    (wr_reg ? page_write_wait_cnt : page_read_wait_cnt);

// programmed waits first, then the pin may extend
// same check on every page read beat
wire waitDone = (k_reg >= target) && !extHold;

// next beat address and page continuation
wire [`CSB_ADDR_W-1:0] addrInc = addr_reg + (`CSB_ADDR_W'h1 << beatLog_reg);
wire more = (left_reg != 4'h0);
// a beat landing on a new page ends the access
wire cont = more && page_reg && !crossBound(addrInc, page_boundary_sel);

// delay counted from the wait end, so 0 and 1 add nothing
// a read with short cs delay still needs its final sample cycle
wire [2:0] endState = (cs_delay_cycles > 3'h1) ? S_CSDLY :
    (!wr_reg ? S_RSAMP : (more ? S_START : S_IDLE));
wire [2:0] endDly = cs_delay_cycles - 3'h2;

// request decode: sizes as log2 bytes
wire [2:0] reqSizeLog = reqBurst ? `CSB_LINE_LOG : {1'b0, reqSize};
wire reqWide = (reqSizeLog > {1'b0, busWidth});
wire [1:0] reqBeatLog = reqWide ? busWidth : reqSizeLog[1:0];
wire [2:0] reqShift = reqSizeLog - {1'b0, reqBeatLog};
// wraps to 15 for sixteen beats on purpose
wire [3:0] reqLeft = (4'h1 << reqShift) - 4'h1;
// page only when enabled and the transfer needs several beats
wire reqPage = (reqWrite ? page_write_enable : page_read_enable) &&
    (reqBurst || reqWide);

// next state of the sequencer
always @*
begin
    st_next = st_reg;
    k_next = k_reg;
    dly_next = dly_reg;
    first_next = first_reg;
    wr_next = wr_reg;
    burst_next = burst_reg;
    page_next = page_reg;
    beatLog_next = beatLog_reg;
    busLog_next = busLog_reg;
    left_next = left_reg;
    addr_next = addr_reg;
    line_next = line_reg;
    adv = 1'b0;
    case (st_reg)
        S_IDLE:
        begin
            // capture the whole request in the idle cycle
            if (reqValid)
            begin
                st_next = S_START;
                wr_next = reqWrite;
                burst_next = reqBurst;
                page_next = reqPage;
                beatLog_next = reqBeatLog;
                busLog_next = busWidth;
                left_next = reqLeft;
                addr_next = reqAddr;
                line_next = reqData;
            end
        end
        S_START:
        begin
            // chip select stays high here; waits count from the next cycle
            st_next = S_WAIT;
            k_next = 5'h00;
            first_next = 1'b1;
        end
        S_WAIT:
        begin
            if (waitDone)
            begin
                // nonzero write delay follows each wait end
                if (wr_reg && (write_data_delay_cycles != 3'h0))
                begin
                    st_next = S_WDLY;
                    dly_next = write_data_delay_cycles - 3'h1;
                end
                // next page write beat right away
                // next page read beat without sample cycle
                else if (cont)
                begin
                    st_next = S_WAIT;
                    k_next = 5'h00;
                    first_next = 1'b0;
                    adv = 1'b1;
                end
                else
                begin
                    st_next = endState;
                    dly_next = endDly;
                    adv = (endState == S_START);
                end
            end
            else if (k_reg != `CSB_WAIT_MAX)
                k_next = k_reg + 5'h01;
        end
        S_WDLY:
        begin
            if (dly_reg != 3'h0)
                dly_next = dly_reg - 3'h1;
            else if (cont)
            begin
                st_next = S_WAIT;
                k_next = 5'h00;
                first_next = 1'b0;
                adv = 1'b1;
            end
            else
            begin
                st_next = endState;
                dly_next = endDly;
                adv = (endState == S_START);
            end
        end
        S_CSDLY:
        begin
            // hold chip select low for the remaining delay
            if (dly_reg != 3'h0)
                dly_next = dly_reg - 3'h1;
            else
            begin
                st_next = more ? S_START : S_IDLE;
                adv = more;
            end
        end
        S_RSAMP:
        begin
            st_next = more ? S_START : S_IDLE;
            adv = more;
        end
        default:
        begin
            st_next = S_IDLE;
        end
    endcase
    // address and data only move once the old beat is fully done
    if (adv)
    begin
        addr_next = addrInc;
        left_next = left_reg - 4'h1;
    end
end

// pin levels derived from the next state so they leave flip-flops
reg csLow, rdLow, weLow, oeOn;
reg [3:0] mask;
reg [2:0] rdAwEff;
reg [`CSB_DATA_W-1:0] word;
always @*
begin
    // cs low through waits once the cs assert wait has passed, write delay and cs delay
    csLow = ((st_next == S_WAIT) && (!first_next || k_next >= {2'b00, csAssertWait})) ||
        (st_next == S_WDLY) || (st_next == S_CSDLY);
    // page read mode one drops the read assert wait
    rdAwEff = (!first_next && page_read_mode_sel) ? 3'h0 : rdAssertWait;
    // a beat restarts at zero cycles, so nonzero waits negate
    rdLow = (st_next == S_WAIT) && !wr_next && (k_next >= {2'b00, rdAwEff});
    // write strobes high outside the wait cycles
    // write assert wait applies on every beat
    weLow = (st_next == S_WAIT) && wr_next && (k_next >= {2'b00, wrAssertWait});
    oeOn = wr_next && csLow;
    mask = laneMask(addr_next[1:0], beatLog_next, busLog_next);
    // single accesses carry data in the low longword
    case (burst_next ? addr_next[3:2] : 2'h0)
        2'h0: word = line_next[31:0];
        2'h1: word = line_next[63:32];
        2'h2: word = line_next[95:64];
        default: word = line_next[127:96];
    endcase
end

// state registers
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        st_reg <= S_IDLE;
        k_reg <= 5'h00;
        dly_reg <= 3'h0;
        first_reg <= 1'b1;
        wr_reg <= 1'b0;
        burst_reg <= 1'b0;
        page_reg <= 1'b0;
        beatLog_reg <= `CSB_SIZE_BYTE;
        busLog_reg <= `CSB_BUS_8;
        left_reg <= 4'h0;
        addr_reg <= `CSB_ADDR_RESET;
        line_reg <= {`CSB_LINE_W{1'b0}};
    end
    else
    begin
        st_reg <= st_next;
        k_reg <= k_next;
        dly_reg <= dly_next;
        first_reg <= first_next;
        wr_reg <= wr_next;
        burst_reg <= burst_next;
        page_reg <= page_next;
        beatLog_reg <= beatLog_next;
        busLog_reg <= busLog_next;
        left_reg <= left_next;
        addr_reg <= addr_next;
        line_reg <= line_next;
    end
end

// read sampling: the wait end cycle's bus level clears the synchroniser
// two edges later, so the read word lags its wait end by three cycles
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        sampleP1_reg <= 1'b0;
        sampleP2_reg <= 1'b0;
        rdValid <= 1'b0;
        rdData <= `CSB_DATA_RESET;
    end
    else
    begin
        sampleP1_reg <= (st_reg == S_WAIT) && waitDone && !wr_reg;
        sampleP2_reg <= sampleP1_reg;
        rdValid <= sampleP2_reg;
        // raw lanes; the master aligns them as it knows the address
        if (sampleP2_reg)
            rdData <= dataSync;
    end
end

// registered pin outputs
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        reqReady <= 1'b0;
        chip_select_n <= 1'b1;
        readStrobeN <= 1'b1;
        writeStrobeN <= `CSB_STROBES_IDLE;
        commonWriteN <= 1'b1;
        byte_control_n <= `CSB_STROBES_IDLE;
        rdWrDir <= 1'b1;
        addrOut <= `CSB_ADDR_RESET;
        dataOut <= `CSB_DATA_RESET;
        dataOe <= 1'b0;
    end
    else
    begin
        reqReady <= (st_next == S_IDLE);
        chip_select_n <= ~csLow;
        // direction low for writes exactly while cs is low
        rdWrDir <= ~(csLow & wr_next);
        readStrobeN <= ~rdLow;
        addrOut <= alignAddr(addr_next, busLog_next);
        dataOut <= laneData(word, addr_next[1:0], busLog_next);
        dataOe <= oeOn;
        // lane strobes on writes only, none on reads
        if (strobe_mode_sel == `CSB_STROBE_BYTE)
        begin
            writeStrobeN <= weLow ? ~mask : `CSB_STROBES_IDLE;
            commonWriteN <= 1'b1;
            byte_control_n <= `CSB_STROBES_IDLE;
        end
        // lane marks for both directions plus common strobe
        else
        begin
            writeStrobeN <= `CSB_STROBES_IDLE;
            commonWriteN <= ~weLow;
            byte_control_n <= csLow ? ~mask : `CSB_STROBES_IDLE;
        end
    end
end

endmodule

// file: tb/csb_page_props.sv
// checker: pin relations of the chip-select page bus sequencer
// assumes configuration levels stay static while an access runs
`timescale 1ns/1ps
`include "csb_consts.vh"
module csb_page_props (
    input wire clk,
    input wire rstn,
    input wire reqValid,
    input wire reqReady,
    input wire [1:0] busWidth,
    input wire strobe_mode_sel,
    input wire chip_select_n,
    input wire readStrobeN,
    input wire [3:0] writeStrobeN,
    input wire commonWriteN,
    input wire [3:0] byte_control_n,
    input wire rdWrDir,
    input wire [`CSB_ADDR_W-1:0] addrOut,
    input wire dataOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // taking a request leaves one start cycle with select high
    property p_start; reqValid && reqReady |=> !reqReady && chip_select_n; endproperty
    a_start: assert property (p_start) else $error("start cycle wrong");
    property p_dir; !rdWrDir |-> !chip_select_n; endproperty
    a_dir: assert property (p_dir) else $error("direction outside select");
    property p_oe; dataOe |-> !chip_select_n && !rdWrDir; endproperty
    a_oe: assert property (p_oe) else $error("data driven outside write");
    property p_rdnowe;
        !strobe_mode_sel && !readStrobeN |-> writeStrobeN == `CSB_STROBES_IDLE;
    endproperty
    a_rdnowe: assert property (p_rdnowe) else $error("lane strobe on read");
    property p_w32; busWidth == `CSB_BUS_32 && !chip_select_n |-> addrOut[1:0] == 2'h0;
    endproperty
    a_w32: assert property (p_w32) else $error("wide address low bits set");
    property p_w16; busWidth == `CSB_BUS_16 && !chip_select_n
            |-> !addrOut[0] && (&writeStrobeN[3:2]) && (&byte_control_n[3:2]);
    endproperty
    a_w16: assert property (p_w16) else $error("half bus lane misuse");
    property p_w8; busWidth == `CSB_BUS_8 && !chip_select_n
            |-> (&writeStrobeN[3:1]) && (&byte_control_n[3:1]);
    endproperty
    a_w8: assert property (p_w8) else $error("byte bus lane misuse");
    property p_one; strobe_mode_sel && !chip_select_n |-> byte_control_n != 4'hF; endproperty
    a_one: assert property (p_one) else $error("no lane marked");
    property p_csidle;
        chip_select_n |-> readStrobeN && commonWriteN && writeStrobeN == `CSB_STROBES_IDLE;
    endproperty
    a_csidle: assert property (p_csidle) else $error("strobe without select");
endmodule
bind csb_page_sequencer csb_page_props i_props (.clk, .rstn, .reqValid, .reqReady,
    .busWidth, .strobe_mode_sel, .chip_select_n, .readStrobeN, .writeStrobeN,
    .commonWriteN, .byte_control_n, .rdWrDir, .addrOut, .dataOe);

// file: tb/csb_ext_mem.sv
// external byte memory model on the chip-select pins
// assumes registered active-low strobes; 256 bytes that wrap on address
`timescale 1ns/1ps
module csb_ext_mem (
    input wire clk,
    input wire chip_select_n,
    input wire strobe_mode_sel,
    input wire [3:0] writeStrobeN,
    input wire commonWriteN,
    input wire [3:0] byte_control_n,
    input wire [25:0] addrOut,
    input wire [31:0] dataOut,
    input wire [3:0] waitLen,
    output wire extWaitN,
    output wire [31:0] dataIn
);
    reg [7:0] mem [0:255];
    reg [31:0] lastData = 32'h0;
    reg [3:0] lowCnt = 4'h0;
    integer i;
    integer j;
    wire [7:0] a = addrOut[7:0];
    wire [31:0] rdWord = {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]};
    // deselected bus shows a changing pattern so stale data cannot match
    assign dataIn = chip_select_n ? ~lastData : rdWord;
    // wait held low for waitLen cycles from select
    assign extWaitN = !(!chip_select_n && lowCnt < waitLen);
    initial for (j = 0; j < 256; j = j + 1) mem[j] = j[7:0];
    // lanes written where their strobe is active
    always @(posedge clk)
    begin
        lastData <= dataIn;
        lowCnt <= chip_select_n ? 4'h0 : lowCnt + 4'h1;
        for (i = 0; i < 4; i = i + 1)
            if (strobe_mode_sel ? (!commonWriteN && !byte_control_n[i]) : !writeStrobeN[i])
                mem[a + i[7:0]] <= dataOut[8*i +: 8];
    end
endmodule

// file: tb/testbench.sv
// self-checking bench for the page bus sequencer
// assumes the external memory model sits on the pin side
`timescale 1ns/1ps
`include "csb_consts.vh"
module testbench;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg reqValid = 1'b0, reqWrite = 1'b0, reqBurst = 1'b0;
    reg [1:0] reqSize = 2'h0, busWidth = 2'h2, page_boundary_sel = 2'h0;
    reg [25:0] reqAddr = 26'h0;
    reg [127:0] reqData = 128'h0;
    reg strobe_mode_sel = 1'b0, page_read_mode_sel = 1'b0, ext_wait_enable = 1'b0;
    reg page_read_enable = 1'b0, page_write_enable = 1'b0;
    reg [4:0] read_cycle_wait_cnt = 5'h1, write_cycle_wait_cnt = 5'h1;
    reg [4:0] page_read_wait_cnt = 5'h1, page_write_wait_cnt = 5'h1;
    reg [2:0] csAssertWait = 3'h0, rdAssertWait = 3'h0, wrAssertWait = 3'h0;
    reg [2:0] write_data_delay_cycles = 3'h0, cs_delay_cycles = 3'h0;
    reg [3:0] waitLen = 4'h0;
    wire reqReady, rdValid, chip_select_n, readStrobeN, commonWriteN, rdWrDir, dataOe;
    wire extWaitN;
    wire [31:0] rdData, dataOut, dataIn;
    wire [3:0] writeStrobeN, byte_control_n;
    wire [25:0] addrOut;
    integer num_errors = 0, samples_checked = 0;
    integer csLow, weLow, weFall, rdHigh, csRise, rdCnt;
    reg [3:0] bcAny, weAny;
    reg [1:0] aOr;
    reg [31:0] lastRd;
    reg weWas = 1'b0, csWas = 1'b1;
    wire weOn = strobe_mode_sel ? !commonWriteN : (writeStrobeN != 4'hF);
    always #50 clk = ~clk;
    csb_page_sequencer i_dut (.clk, .rstn, .reqValid, .reqWrite, .reqBurst, .reqSize,
        .reqAddr, .reqData, .reqReady, .rdValid, .rdData, .busWidth, .strobe_mode_sel,
        .page_read_mode_sel, .page_read_enable, .page_write_enable, .page_boundary_sel,
        .ext_wait_enable, .read_cycle_wait_cnt, .write_cycle_wait_cnt, .page_read_wait_cnt,
        .page_write_wait_cnt, .csAssertWait, .rdAssertWait, .wrAssertWait,
        .write_data_delay_cycles, .cs_delay_cycles, .extWaitN, .dataIn, .chip_select_n,
        .readStrobeN, .writeStrobeN, .commonWriteN, .byte_control_n, .rdWrDir, .addrOut,
        .dataOut, .dataOe);
    csb_ext_mem i_mem (.clk, .chip_select_n, .strobe_mode_sel, .writeStrobeN, .commonWriteN,
        .byte_control_n, .addrOut, .dataOut, .waitLen, .extWaitN, .dataIn);
    // pin tallies taken mid-cycle, where registered outputs have settled
    always @(negedge clk)
    begin
        if (!chip_select_n)
        begin
            csLow = csLow + 1;
            weLow = weLow + weOn;
            weFall = weFall + (weOn && !weWas);
            rdHigh = rdHigh + readStrobeN;
            bcAny = bcAny & byte_control_n;
            weAny = weAny & writeStrobeN;
            aOr = aOr | addrOut[1:0];
        end
        csRise = csRise + (chip_select_n && !csWas);
        if (rdValid === 1'b1)
        begin
            rdCnt = rdCnt + 1;
            lastRd = rdData;
        end
        weWas = weOn;
        csWas = chip_select_n;
    end
    task check(input [31:0] seen, input [31:0] exp, input [8*12-1:0] what);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp)
            begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED t=%0t %0s seen %h exp %h", $time, what, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // one access: hold the request until taken, then wait for idle and read lag
    task run(input w, input [1:0] sz, input [25:0] a, input [127:0] d);
        integer n;
        begin
            csLow = 0; weLow = 0; weFall = 0; rdHigh = 0; csRise = 0; rdCnt = 0;
            bcAny = 4'hF; weAny = 4'hF; aOr = 2'h0;
            @(posedge clk);
            reqValid <= 1'b1; reqWrite <= w; reqSize <= sz; reqAddr <= a; reqData <= d;
            n = 0;
            @(negedge clk);
            while (reqReady !== 1'b1 && n < 50) begin @(negedge clk); n = n + 1; end
            @(posedge clk);
            reqValid <= 1'b0;
            repeat (2) @(negedge clk);
            while (reqReady !== 1'b1 && n < 200) begin @(negedge clk); n = n + 1; end
            if (n >= 200) num_errors = num_errors + 1;
            repeat (6) @(posedge clk);
        end
    endtask
    // common settings, changed only while the sequencer is idle
    task base(input [1:0] bw);
        begin
            @(posedge clk);
            busWidth <= bw; strobe_mode_sel <= 1'b0; page_read_mode_sel <= 1'b0;
            page_read_enable <= 1'b1; page_write_enable <= 1'b1; ext_wait_enable <= 1'b0;
            read_cycle_wait_cnt <= 5'h1; write_cycle_wait_cnt <= 5'h1; waitLen <= 4'h0;
            page_read_wait_cnt <= 5'h1; page_write_wait_cnt <= 5'h1; rdAssertWait <= 3'h0;
            wrAssertWait <= 3'h0; write_data_delay_cycles <= 3'h0; cs_delay_cycles <= 3'h0;
        end
    endtask
    task t_cs_delay;
        integer i;
        begin
            base(`CSB_BUS_32);
            for (i = 0; i < 5; i = i + 1)
            begin
                read_cycle_wait_cnt <= (i == 3) ? 5'h1F : (i == 4) ? 5'h00 : 5'h01;
                cs_delay_cycles <= (i == 2) ? 3'h3 : (i == 1) ? 3'h1 : 3'h0;
                {csAssertWait, rdAssertWait} <= (i == 3) ? 6'h12 : 6'h00;
                run(1'b0, `CSB_SIZE_LONG, 26'h40, 128'h0);
                check(csLow, (i == 3) ? 30 : (i == 4) ? 1 : (i == 2) ? 4 : 2, "cs low");
                check(rdCnt, 1, "beats");
            end
            $display("test cs delay done");
        end
    endtask
    task t_page_write;
        integer i;
        begin
            base(`CSB_BUS_16);
            for (i = 0; i < 4; i = i + 1)
            begin
                write_cycle_wait_cnt <= (i == 0) ? 5'h2 : 5'h1;
                page_write_wait_cnt <= (i == 0) ? 5'h0 : 5'h1;
                wrAssertWait <= (i == 1) ? 3'h1 : 3'h0;
                write_data_delay_cycles <= (i == 2) ? 3'h2 : 3'h0;
                page_write_enable <= (i != 3);
                run(1'b1, `CSB_SIZE_LONG, 26'h60, 128'hA5A5C3C3);
                check(weLow, (i == 1) ? 2 : 4, "we low");
                check(weFall, (i == 0) ? 1 : 2, "we falls");
                check(csRise, (i == 3) ? 2 : 1, "accesses");
                if (i == 0) check(csLow, 4, "cs low");
            end
            $display("test page write done");
        end
    endtask
    task t_page_read;
        begin
            base(`CSB_BUS_16);
            read_cycle_wait_cnt <= 5'h2;
            run(1'b0, `CSB_SIZE_LONG, 26'h80, 128'h0);
            check(csLow, 5, "cs low");
            check(rdCnt, 2, "beats");
            check(csRise, 1, "accesses");
            page_read_wait_cnt <= 5'h2; rdAssertWait <= 3'h2;
            run(1'b0, `CSB_SIZE_LONG, 26'h80, 128'h0);
            check(rdHigh, 4, "rd high");
            page_read_mode_sel <= 1'b1;
            run(1'b0, `CSB_SIZE_LONG, 26'h80, 128'h0);
            check(rdHigh, 2, "rd high");
            $display("test page read done");
        end
    endtask
    task t_ext_wait;
        begin
            base(`CSB_BUS_32);
            read_cycle_wait_cnt <= 5'h3; waitLen <= 4'h4;
            run(1'b0, `CSB_SIZE_LONG, 26'h40, 128'h0);
            check(csLow, 4, "ignored");
            ext_wait_enable <= 1'b1;
            run(1'b0, `CSB_SIZE_LONG, 26'h40, 128'h0);
            check(csLow, 7, "extended");
            waitLen <= 4'h0;
            run(1'b0, `CSB_SIZE_LONG, 26'h40, 128'h0);
            check(csLow, 4, "programmed");
            busWidth <= `CSB_BUS_16; read_cycle_wait_cnt <= 5'h0;
            page_read_wait_cnt <= 5'h3; waitLen <= 4'h4;
            run(1'b0, `CSB_SIZE_LONG, 26'h80, 128'h0);
            check(csLow, 7, "page ext");
            $display("test external wait done");
        end
    endtask
    task t_strobes;
        begin
            base(`CSB_BUS_32);
            run(1'b1, `CSB_SIZE_LONG, 26'h40, 128'h12345678);
            run(1'b0, `CSB_SIZE_LONG, 26'h40, 128'h0);
            check(lastRd, 32'h12345678, "round trip");
            check(weAny, 4'hF, "read lanes");
            run(1'b1, `CSB_SIZE_BYTE, 26'h41, 128'hAB00);
            check($countones(~weAny), 1, "byte lane");
            strobe_mode_sel <= 1'b1;
            run(1'b1, `CSB_SIZE_BYTE, 26'h42, 128'hCD0000);
            check(weFall, 1, "common we");
            check($countones(~bcAny), 1, "byte mark");
            run(1'b0, `CSB_SIZE_LONG, 26'h40, 128'h0);
            check(bcAny, 4'h0, "read marks");
            check(weFall, 0, "no we");
            busWidth <= `CSB_BUS_8; strobe_mode_sel <= 1'b0;
            run(1'b0, `CSB_SIZE_WORD, 26'h12, 128'h0);
            check(aOr, 2'h3, "byte addr");
            check(rdCnt, 2, "beats");
            $display("test strobes done");
        end
    endtask
    initial
    begin
        #(100 * 20000);
        num_errors = num_errors + 1;
        finish_test;
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_cs_delay;
        t_page_write;
        t_page_read;
        t_ext_wait;
        t_strobes;
        finish_test;
    end
endmodule
